/* File: hdl/screen_ram_pkg.sv */
package screen_ram_pkg;
  // engine timing; I_CLK stands in for the single crystal source
  localparam int         CLK_PERIOD_NS   = 10;
  localparam int         CRYSTAL_X1000   = 45692;
  localparam int         LINE_TIME_NS    = 63131;
  localparam int         FRAME_TIME_US   = 16666;
  localparam int         PIXELS_PER_LINE = 960;
  localparam logic [3:0] LAST_STEP       = 4'hB;
  localparam logic [3:0] LOAD_STEP       = 4'h2;
  localparam logic [3:0] READ_END_STEP   = 4'h5;
  localparam logic [6:0] LAST_WORD       = 7'h4F;
  localparam logic [6:0] DISP_WORDS      = 7'h40;
  localparam logic [6:0] VSYNC_ROWS      = 7'h04;
  localparam logic [8:0] FRAME_LINES     = 9'h108;
  localparam logic [8:0] DISPLAY_LINES   = 9'h0F4;

  // register byte offsets
  localparam logic [5:0] OFS_X      = 6'h00;
  localparam logic [5:0] OFS_Y      = 6'h04;
  localparam logic [5:0] OFS_PAT    = 6'h08;
  localparam logic [5:0] OFS_MULT   = 6'h0C;
  localparam logic [5:0] OFS_WRITE_OPTIONS_REG   = 6'h10;
  localparam logic [5:0] OFS_EXEC   = 6'h14;
  localparam logic [5:0] OFS_VTOTAL = 6'h18;
  localparam logic [5:0] OFS_VADJ   = 6'h1C;
  localparam logic [5:0] OFS_VDISP  = 6'h20;
  localparam logic [5:0] OFS_VSYNC  = 6'h24;
  localparam logic [5:0] OFS_ILACE  = 6'h28;

  // reset values
  localparam logic [7:0] RST_PAT    = 8'hFF;
  localparam logic [3:0] RST_MULT   = 4'hF;
  localparam logic [7:0] RST_WRITE_OPTIONS_REG   = 8'h00;
  localparam logic [6:0] RST_VTOTAL = 7'h41;
  localparam logic [4:0] RST_VADJ   = 5'h00;
  localparam logic [6:0] RST_VDISP  = 7'h3D;
  localparam logic [6:0] RST_VSYNC  = 7'h3E;
  localparam logic [1:0] RST_ILACE  = 2'h0;

  // field positions
  localparam int WRITE_OPTIONS_REG_NEG_BIT  = 0;
  localparam int WRITE_OPTIONS_REG_FUNC_LSB = 1;
  localparam int WRITE_OPTIONS_REG_ATTR_EN  = 3;
  localparam int WRITE_OPTIONS_REG_ATTR_LSB = 4;
  localparam int ATTR_LSB      = 12;

  typedef enum logic [1:0] {FN_OVERLAY, FN_REPLACE, FN_COMPLEMENT, FN_ERASE} write_func_t;

  typedef struct packed {
    logic [6:0]  addr;
    logic        ras;
    logic        cas;
    logic        we;
    logic [15:0] wdata;
  } ram_cmd_t;

  typedef struct packed {
    logic [6:0] row;
    logic [6:0] col;
    logic [1:0] bank;
    logic [1:0] bit_sel;
  } modify_target_t;
endpackage

/* File: hdl/screen_ram_refresh_modify.sv */
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - frame is 264 lines, 244 displayed
// - vertical counted in four-line rows, 66 rows
// - rows 0-60 shown, one porch, four sync
// - frame repeats at 60 Hz, 16.666 ms
// - all timing from the one clock
// - modify and refresh interleave on memory
// - modify reads word, changes one bit, writes
// - sequential refresh words shift out bitwise
// - select high picks xy, low refresh
// - modify row Y1,(X9-X2)/3; column Y8-Y2
// - refresh row RA0,MA5-0; column MA11-6,RA1
// - translator never yields bank three
// - X9-X2 mod 3 picks bank; X1,X0 pick bit
// - multiplier sets uses per pattern shift
// - new bit from pattern and option function
// - options 2:1 pick function, bit0 negates
// - select toggles every three of twelve steps
// - enabled attribute bits written on modify
module screen_ram_refresh_modify #(
  parameter int P_LINE_CYCLES = screen_ram_pkg::LINE_TIME_NS / screen_ram_pkg::CLK_PERIOD_NS
) (
  input  wire logic                     I_CLK,
  input  wire logic                     I_RESET,
  input  wire logic [5:0]               I_AVS_ADDRESS,
  input  wire logic                     I_AVS_READ,
  input  wire logic                     I_AVS_WRITE,
  input  wire logic [31:0]              I_AVS_WRITEDATA,
  input  wire logic [3:0]               I_AVS_BYTEENABLE,
  output logic      [31:0]              O_AVS_READDATA,
  output logic                          O_AVS_WAITREQUEST,
  input  wire logic [15:0]              I_RAM_RDATA,
  output screen_ram_pkg::ram_cmd_t      O_RAM,
  output logic                          O_MODIFY_REFRESH_SELECT,
  output logic                          O_VIDEO,
  output logic                          O_BLANK,
  output logic                          O_VSYNC
);

  typedef enum logic [1:0] {ST_IDLE, ST_PEND, ST_READ, ST_WRITE} mod_state_t;

  localparam logic [12:0] LINE_CYC = 13'(P_LINE_CYCLES);
  localparam logic [12:0] PIX_INC  = 13'(screen_ram_pkg::PIXELS_PER_LINE);

  // step position and phase inside the twelve-step sequence
  function automatic logic [1:0] phase_of(input logic [3:0] s);
    phase_of = 2'(s / 4'h3);
  endfunction

  function automatic logic [1:0] pos_of(input logic [3:0] s);
    pos_of = 2'(s % 4'h3);
  endfunction

  // pixel-group index to word and bank; remainder of three keeps bank below 3
  function automatic logic [7:0] translate(input logic [7:0] g);
    translate = {6'(g / 8'h03), 2'(g % 8'h03)};
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  function automatic logic [3:0] neg4(input logic [3:0] m);
    neg4 = 4'(~m + 4'h1);
  endfunction

  function automatic logic new_bit(input logic a, input logic p, input logic [7:0] w);
    logic pn;
    pn = p ^ w[screen_ram_pkg::WRITE_OPTIONS_REG_NEG_BIT];
    case (screen_ram_pkg::write_func_t'(w[screen_ram_pkg::WRITE_OPTIONS_REG_FUNC_LSB +: 2]))
      screen_ram_pkg::FN_OVERLAY:    new_bit = a | pn;
      screen_ram_pkg::FN_REPLACE:    new_bit = pn;
      screen_ram_pkg::FN_COMPLEMENT: new_bit = a ^ pn;
      default:                       new_bit = w[screen_ram_pkg::WRITE_OPTIONS_REG_NEG_BIT];
    endcase
  endfunction

  function automatic logic [15:0] modify_word(input logic [15:0] rd, input logic [3:0] idx,
                                              input logic p, input logic [7:0] w);
    logic [15:0] m;
    m = rd;
    m[idx] = new_bit(rd[idx], p, w);
    if (w[screen_ram_pkg::WRITE_OPTIONS_REG_ATTR_EN]) begin
      m[screen_ram_pkg::ATTR_LSB +: 4] = w[screen_ram_pkg::WRITE_OPTIONS_REG_ATTR_LSB +: 4];
    end
    modify_word = m;
  endfunction

  logic [12:0]                    acc_q;
  logic [3:0]                     step_q;
  logic [6:0]                     word_q;
  logic [8:0]                     line_q;
  logic [9:0]                     x_q;
  logic [8:0]                     y_q;
  logic [7:0]                     pat_q;
  logic [3:0]                     mult_q;
  logic [3:0]                     count_q;
  logic [7:0]                     write_options_reg_q;
  logic [6:0]                     vtotal_q;
  logic [4:0]                     vadj_q;
  logic [6:0]                     vdisp_q;
  logic [6:0]                     vsync_q;
  logic [1:0]                     ilace_q;
  logic [15:0]                    rd_s1_q;
  logic [15:0]                    rd_s2_q;
  logic [11:0]                    shift_q;
  logic                           wait_q;
  logic [31:0]                    rdata_q;
  logic [31:0]                    rdata_w;
  mod_state_t                     state_q;
  mod_state_t                     state_d;
  screen_ram_pkg::modify_target_t tgt_q;
  screen_ram_pkg::ram_cmd_t       ram_q;

  // pixel tick: 960 ticks spread evenly over one line period of the system clock
  wire [13:0] acc_sum  = {1'b0, acc_q} + {1'b0, PIX_INC};
  wire        tick     = acc_sum >= {1'b0, LINE_CYC};
  wire [12:0] acc_d    = tick ? 13'(acc_sum - {1'b0, LINE_CYC}) : acc_sum[12:0];

  // twelve-step sequence; odd phases belong to modify, even to refresh
  wire [3:0]  step_d   = !tick ? step_q :
                         (step_q == screen_ram_pkg::LAST_STEP) ? 4'h0 : 4'(step_q + 4'h1);
  wire [1:0]  ph_d     = phase_of(step_d);
  wire [1:0]  pos_d    = pos_of(step_d);
  wire        sel_d    = ph_d[0];
  wire        word_end = tick && (step_q == screen_ram_pkg::LAST_STEP);
  wire        load     = tick && (step_q == screen_ram_pkg::LOAD_STEP);

  // raster position: words per line, scan lines per frame
  wire        line_end  = word_end && (word_q == screen_ram_pkg::LAST_WORD);
  wire [6:0]  word_d    = !word_end ? word_q :
                          (word_q == screen_ram_pkg::LAST_WORD) ? 7'h00 : 7'(word_q + 7'h01);
  wire [8:0]  last_line = 9'({vtotal_q, 2'b00} + 9'h003 + 9'(vadj_q));
  wire [8:0]  line_d    = !line_end ? line_q :
                          (line_q == last_line) ? 9'h000 : 9'(line_q + 9'h001);
  wire [6:0]  row       = line_q[8:2];
  wire        disp_row  = row < vdisp_q;
  wire        sync_row  = (row >= vsync_q) &&
                          (row < 7'(vsync_q + screen_ram_pkg::VSYNC_ROWS));

  // refresh address built from the next word and scan line
  wire [6:0]  ref_row_d = {line_d[0], word_d[5:0]};
  wire [6:0]  ref_col_d = {line_d[7:2], line_d[1]};
  wire [6:0]  mod_addr  = (pos_d == 2'h0) ? tgt_q.row : tgt_q.col;
  wire [6:0]  ref_addr  = (pos_d == 2'h0) ? ref_row_d : ref_col_d;

  // modify target from the xy registers through the bank translator
  wire [7:0]  tba       = translate(x_q[9:2]);
  wire [3:0]  idx       = {tgt_q.bank, tgt_q.bit_sel};
  wire        capture   = tick && (step_q == screen_ram_pkg::READ_END_STEP) && (state_q == ST_READ);
  wire        wr_done   = word_end && (state_q == ST_WRITE);

  // bus decode; an execute while busy is held off by waitrequest
  wire        req       = I_AVS_READ || I_AVS_WRITE;
  wire        a_exec    = I_AVS_ADDRESS == screen_ram_pkg::OFS_EXEC;
  wire        stall     = I_AVS_WRITE && a_exec && (state_q != ST_IDLE);
  wire        ack       = req && wait_q && !stall;
  wire        wr_fire   = I_AVS_WRITE && !wait_q;
  wire        exec_fire = wr_fire && a_exec;
  wire [15:0] wd16      = I_AVS_WRITEDATA[15:0];
  wire [1:0]  be2       = I_AVS_BYTEENABLE[1:0];
  wire [3:0]  mult_new  = 4'(merge16(16'(mult_q), wd16, be2));

  // memory command for the next step; outputs hold between ticks, except the modify address when an execute retargets it
  wire screen_ram_pkg::ram_cmd_t ram_d = '{
    addr:  sel_d ? mod_addr : ref_addr,
    ras:   pos_d == 2'h0,
    cas:   pos_d == 2'h1,
    we:    sel_d && (ph_d == 2'h3) && (state_d == ST_WRITE),
    wdata: capture ? modify_word(rd_s2_q, idx, pat_q[0], write_options_reg_q) : ram_q.wdata
  };

  // register readback; unmapped offsets read as zero
  always_comb begin
    rdata_w = 32'h0000_0000;
    case (I_AVS_ADDRESS)
      screen_ram_pkg::OFS_X:      rdata_w = 32'(x_q);
      screen_ram_pkg::OFS_Y:      rdata_w = 32'(y_q);
      screen_ram_pkg::OFS_PAT:    rdata_w = 32'(pat_q);
      screen_ram_pkg::OFS_MULT:   rdata_w = 32'(mult_q);
      screen_ram_pkg::OFS_WRITE_OPTIONS_REG:   rdata_w = 32'(write_options_reg_q);
      screen_ram_pkg::OFS_EXEC:   rdata_w = 32'({O_VSYNC, O_BLANK, state_q != ST_IDLE});
      screen_ram_pkg::OFS_VTOTAL: rdata_w = 32'(vtotal_q);
      screen_ram_pkg::OFS_VADJ:   rdata_w = 32'(vadj_q);
      screen_ram_pkg::OFS_VDISP:  rdata_w = 32'(vdisp_q);
      screen_ram_pkg::OFS_VSYNC:  rdata_w = 32'(vsync_q);
      screen_ram_pkg::OFS_ILACE:  rdata_w = 32'(ilace_q);
      default:                    rdata_w = 32'h0000_0000;
    endcase
  end

  // modify sequencer: waits for phase B, reads, writes back in phase D
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:  if (exec_fire) state_d = ST_PEND;
      ST_PEND:  if (load) state_d = ST_READ;
      ST_READ:  if (capture) state_d = ST_WRITE;
      ST_WRITE: if (wr_done) state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  // bus handshake: one wait cycle, effect at the edge waitrequest is low
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q  <= !ack;
      rdata_q <= ack ? rdata_w : rdata_q;
    end
  end

  // software-loaded setup; vertical values reset to the standard frame
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      x_q      <= 10'h000;
      y_q      <= 9'h000;
      mult_q   <= screen_ram_pkg::RST_MULT;
      write_options_reg_q   <= screen_ram_pkg::RST_WRITE_OPTIONS_REG;
      vtotal_q <= screen_ram_pkg::RST_VTOTAL;
      vadj_q   <= screen_ram_pkg::RST_VADJ;
      vdisp_q  <= screen_ram_pkg::RST_VDISP;
      vsync_q  <= screen_ram_pkg::RST_VSYNC;
      ilace_q  <= screen_ram_pkg::RST_ILACE; // only non-interlaced scan is produced
    end else if (wr_fire) begin
      case (I_AVS_ADDRESS)
        screen_ram_pkg::OFS_X:      x_q      <= 10'(merge16(16'(x_q), wd16, be2));
        screen_ram_pkg::OFS_Y:      y_q      <= 9'(merge16(16'(y_q), wd16, be2));
        screen_ram_pkg::OFS_MULT:   mult_q   <= mult_new;
        screen_ram_pkg::OFS_WRITE_OPTIONS_REG:   write_options_reg_q   <= 8'(merge16(16'(write_options_reg_q), wd16, be2));
        screen_ram_pkg::OFS_VTOTAL: vtotal_q <= 7'(merge16(16'(vtotal_q), wd16, be2));
        screen_ram_pkg::OFS_VADJ:   vadj_q   <= 5'(merge16(16'(vadj_q), wd16, be2));
        screen_ram_pkg::OFS_VDISP:  vdisp_q  <= 7'(merge16(16'(vdisp_q), wd16, be2));
        screen_ram_pkg::OFS_VSYNC:  vsync_q  <= 7'(merge16(16'(vsync_q), wd16, be2));
        screen_ram_pkg::OFS_ILACE:  ilace_q  <= 2'(merge16(16'(ilace_q), wd16, be2));
        default: ;
      endcase
    end
  end

  // pattern and its use counter; a software load overrides an advance
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      pat_q   <= screen_ram_pkg::RST_PAT;
      count_q <= neg4(screen_ram_pkg::RST_MULT);
    end else if (wr_fire && (I_AVS_ADDRESS == screen_ram_pkg::OFS_PAT)) begin
      pat_q   <= 8'(merge16(16'(pat_q), wd16, be2));
      count_q <= neg4(mult_q);
    end else if (wr_fire && (I_AVS_ADDRESS == screen_ram_pkg::OFS_MULT)) begin
      count_q <= neg4(mult_new);
    end else if (wr_done && (count_q == 4'h1)) begin
      pat_q   <= {pat_q[0], pat_q[7:1]};
      count_q <= neg4(mult_q);
    end else if (wr_done) begin
      count_q <= 4'(count_q - 4'h1);
    end
  end

  // timing chain and modify target
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      acc_q   <= 13'h0000;
      step_q  <= 4'h0;
      word_q  <= 7'h00;
      line_q  <= 9'h000;
      state_q <= ST_IDLE;
      tgt_q   <= '0;
    end else begin
      acc_q   <= acc_d;
      step_q  <= step_d;
      word_q  <= word_d;
      line_q  <= line_d;
      state_q <= state_d;
      if (exec_fire) begin
        tgt_q <= '{row: {y_q[1], tba[7:2]}, col: y_q[8:2],
                   bank: tba[1:0], bit_sel: x_q[1:0]};
      end
    end
  end

  // read data crosses in from the pins through two flops
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      rd_s1_q <= 16'h0000;
      rd_s2_q <= 16'h0000;
    end else begin
      rd_s1_q <= I_RAM_RDATA;
      rd_s2_q <= rd_s1_q;
    end
  end

  // pixel shifter: the reload tick is also the tick the last bit leaves
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      shift_q <= 12'h000;
      O_VIDEO <= 1'b0;
      O_BLANK <= 1'b1;
      O_VSYNC <= 1'b0;
    end else if (load) begin
      shift_q <= {1'b0, rd_s2_q[11:1]};
      O_VIDEO <= rd_s2_q[0] && disp_row && (word_q < screen_ram_pkg::DISP_WORDS);
      O_BLANK <= !disp_row || (word_q >= screen_ram_pkg::DISP_WORDS);
      O_VSYNC <= sync_row;
    end else if (tick) begin
      shift_q <= {1'b0, shift_q[11:1]};
      O_VIDEO <= shift_q[0] && !O_BLANK;
    end
  end

  // memory command and select leave straight from flops
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      ram_q                   <= '0;
      O_MODIFY_REFRESH_SELECT <= 1'b0;
    end else begin
      ram_q                   <= ram_d;
      O_MODIFY_REFRESH_SELECT <= sel_d;
    end
  end

  assign O_RAM             = ram_q;
  assign O_AVS_READDATA    = rdata_q;
  assign O_AVS_WAITREQUEST = wait_q;

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);

  // frame length rebuilt from rows of four lines, so a short test frame exercises it too
  a_frame_wrap: assert property (
    (line_end && line_q == 9'((({3'b000, vtotal_q} + 10'h001) << 2) + 10'(vadj_q) - 10'h001))
    |=> line_q == 9'h000)
    else $error("frame did not wrap after its last line");
  a_default_frame: assert property (
    (vtotal_q == screen_ram_pkg::RST_VTOTAL && vadj_q == screen_ram_pkg::RST_VADJ) |->
    last_line == 9'(screen_ram_pkg::FRAME_LINES - 9'h001))
    else $error("default frame is not 264 lines");
  a_row_shown: assert property (
    (load && line_q < screen_ram_pkg::DISPLAY_LINES && vdisp_q == screen_ram_pkg::RST_VDISP &&
     word_q < screen_ram_pkg::DISP_WORDS) |=> !O_BLANK)
    else $error("displayed row was blanked");
  a_vsync_rows: assert property (
    (load && vsync_q == screen_ram_pkg::RST_VSYNC) |=> O_VSYNC == (($past(row) >= 7'h3E)
     && ($past(row) <= 7'h41)))
    else $error("vertical sync outside rows 62 to 65");
  a_select_modify: assert property (
    (tick && step_q == screen_ram_pkg::LOAD_STEP) |=> O_MODIFY_REFRESH_SELECT)
    else $error("select not high in modify phase");
  a_select_refresh: assert property (
    (tick && step_q == screen_ram_pkg::READ_END_STEP) |=> !O_MODIFY_REFRESH_SELECT)
    else $error("select not low in refresh phase");
  a_ras_then_cas: assert property (
    $fell(O_RAM.ras) |-> O_RAM.cas)
    else $error("column strobe does not follow row strobe");
  // an execute while idle may retarget on the strobe edge itself, so only busy phases count
  a_modify_row: assert property (
    ($rose(O_RAM.ras) && O_MODIFY_REFRESH_SELECT && (state_q == ST_READ || state_q == ST_WRITE))
    |-> O_RAM.addr == tgt_q.row)
    else $error("modify row address wrong");
  a_refresh_row: assert property (
    ($rose(O_RAM.ras) && !O_MODIFY_REFRESH_SELECT) |-> O_RAM.addr == {line_q[0], word_q[5:0]})
    else $error("refresh row address wrong");
  a_bank_legal: assert property (
    (state_q != ST_IDLE) |-> tgt_q.bank != 2'h3)
    else $error("bank three selected");
  a_one_bit: assert property (
    capture |=> ((O_RAM.wdata[11:0] ^ $past(rd_s2_q[11:0])) & ~(12'h001 << $past(idx))) == 12'h000)
    else $error("modify touched more than one pixel");
  a_complement: assert property (
    (capture && write_options_reg_q[2:0] == 3'b100) |=>
    O_RAM.wdata[$past(idx)] == ($past(rd_s2_q[idx]) ^ $past(pat_q[0])))
    else $error("complement result wrong");
  a_we_in_modify: assert property (
    O_RAM.we |-> (O_MODIFY_REFRESH_SELECT && state_q == ST_WRITE))
    else $error("write strobe outside modify write-back");
  a_pattern_hold: assert property (
    (wr_done && count_q != 4'h1 && !wr_fire) |=> $stable(pat_q))
    else $error("pattern shifted before its uses ran out");
  a_pattern_rotate: assert property (
    (wr_done && count_q == 4'h1 && !wr_fire) |=> pat_q == {$past(pat_q[0]), $past(pat_q[7:1])})
    else $error("pattern did not rotate");

endmodule

`default_nettype wire

/* File: tb/screen_ram_model.sv */
`timescale 1ns/1ps
`default_nettype none
// behavioural screen dram: row on ras, column and data on cas
module screen_ram_model (
  input  wire screen_ram_pkg::ram_cmd_t i_cmd,
  input  wire logic                     i_clk,
  output logic [15:0]                   o_rdata
);
  logic [15:0] mem [0:16383];
  logic [6:0]  row_q = 7'h00;
  logic        cas_q = 1'b0;
  logic        valid_q = 1'b0;
  logic [15:0] data_q = 16'h0000;
  // data stands from cas until the next ras; otherwise the pins show the inverse
  assign o_rdata = i_cmd.cas ? mem[{row_q, i_cmd.addr}] : (valid_q ? data_q : ~data_q);
  // one access per ras/cas pair, write-back when we is high
  always @(posedge i_clk) begin
    cas_q <= i_cmd.cas;
    if (i_cmd.ras) begin
      row_q   <= i_cmd.addr;
      valid_q <= 1'b0;
    end
    if (i_cmd.cas && !cas_q) begin
      valid_q <= 1'b1;
      data_q  <= mem[{row_q, i_cmd.addr}];
      if (i_cmd.we) begin
        mem[{row_q, i_cmd.addr}] <= i_cmd.wdata;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb_screen_ram_refresh_modify.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_screen_ram_refresh_modify;
  localparam int P = 1920; // two clocks per pixel tick so synchronised ram data can settle
  logic                     clk = 1'b0;
  logic                     rst = 1'b1;
  logic [5:0]               addr = 6'h00;
  logic                     rd = 1'b0;
  logic                     wr = 1'b0;
  logic [31:0]              wd = 32'h0000_0000;
  logic [31:0]              rdat;
  logic                     wait_req;
  logic [15:0]              ram_rd;
  screen_ram_pkg::ram_cmd_t ram;
  logic                     sel;
  logic                     vsync;
  logic                     video;
  logic                     blank;
  int                       bad_count = 0;
  int                       cmp_count = 0;
  logic [31:0]              q;
  logic [15:0]              w;
  logic                     b;
  int                       lo;
  int                       hi;
  screen_ram_refresh_modify #(.P_LINE_CYCLES(P)) u_screen_ram_refresh_modify (
    .I_CLK(clk), .I_RESET(rst), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
    .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(4'h3), .O_AVS_READDATA(rdat),
    .O_AVS_WAITREQUEST(wait_req), .I_RAM_RDATA(ram_rd), .O_RAM(ram),
    .O_MODIFY_REFRESH_SELECT(sel), .O_VIDEO(video), .O_BLANK(blank), .O_VSYNC(vsync));
  screen_ram_model u_screen_ram_model (.i_cmd(ram), .i_clk(clk), .o_rdata(ram_rd));
  // 100 MHz clock
  always #5 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w_n, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd <= ~w_n;
    wr <= w_n;
    addr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 1000);
    if (wait_req !== 1'b0) begin
      bad_count++;
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // measure one run of a level on vsync or on the select line
  task automatic run_len(input logic vs, input logic lvl, output int n);
    n = 0;
    while (((vs ? vsync : sel) === lvl) && n < 40000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40000) begin
      bad_count++;
    end
  endtask
  // preset a word, point at it, execute and return the word written back
  task automatic do_mod(input logic [9:0] x, input logic [8:0] y, input logic [15:0] old);
    logic [7:0] t;
    int n;
    t = {6'(x[9:2] / 3), 2'(x[9:2] % 3)};
    b = old[t[1:0] * 4 + x[1:0]];
    u_screen_ram_model.mem[{y[1], t[7:2], y[8:2]}] = old;
    bus(1'b1, screen_ram_pkg::OFS_X, {22'h0, x});
    bus(1'b1, screen_ram_pkg::OFS_Y, {23'h0, y});
    bus(1'b1, screen_ram_pkg::OFS_EXEC, 32'h0000_0000);
    n = 0;
    do begin
      bus(1'b0, screen_ram_pkg::OFS_EXEC, 32'h0000_0000);
      n++;
    end while (q[0] !== 1'b0 && n < 100);
    if (q[0] !== 1'b0) begin
      bad_count++;
    end
    w = u_screen_ram_model.mem[{y[1], t[7:2], y[8:2]}];
    w = w >> (t[1:0] * 4 + x[1:0]);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // watchdog: the frame test alone may wait about forty lines of P clocks
  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    conclude();
  end
  initial begin
    logic [15:0] old;
    logic [7:0]  write_options_reg;
    logic        a;
    logic        m;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, screen_ram_pkg::OFS_VTOTAL, 32'h0); chk(q, 32'h0000_0041);
    bus(1'b0, screen_ram_pkg::OFS_VADJ, 32'h0); chk(q, 32'h0000_0000);
    bus(1'b0, screen_ram_pkg::OFS_VDISP, 32'h0); chk(q, 32'h0000_003D);
    bus(1'b0, screen_ram_pkg::OFS_VSYNC, 32'h0); chk(q, 32'h0000_003E);
    bus(1'b0, screen_ram_pkg::OFS_MULT, 32'h0); chk(q, 32'h0000_000F);
    bus(1'b1, 6'h30, 32'h0000_FFFF);
    bus(1'b0, 6'h30, 32'h0); chk(q, 32'h0000_0000);
    $display("test registers done");
    // select line: three steps high, three low
    run_len(1'b0, 1'b0, lo);
    run_len(1'b0, 1'b1, lo);
    run_len(1'b0, 1'b0, lo);
    run_len(1'b0, 1'b1, hi);
    chk(lo, 32'(3 * P / screen_ram_pkg::PIXELS_PER_LINE));
    chk(hi, 32'(3 * P / screen_ram_pkg::PIXELS_PER_LINE));
    $display("test select done");
    // every function, with and without negate and attribute write
    for (int f = 0; f < 8; f++) begin
      write_options_reg = {4'(4'h5 ^ f), f[0], 3'(f)};
      bus(1'b1, screen_ram_pkg::OFS_WRITE_OPTIONS_REG, {24'h0, write_options_reg});
      old = (f < 4) ? 16'h0A5C : 16'h35A3;
      do_mod(10'(100 + 83 * f), 9'(50 + 23 * f), old);
      a = b; // the selected bit as it stood before the modify
      case (write_options_reg[2:1])
        2'b00: m = a | (1'b1 ^ write_options_reg[0]);
        2'b01: m = 1'b1 ^ write_options_reg[0];
        2'b10: m = a ^ (1'b1 ^ write_options_reg[0]);
        default: m = write_options_reg[0];
      endcase
      chk({31'h0, w[0]}, {31'h0, m});
    end
    $display("test functions done");
    // attribute written on modify when enabled
    bus(1'b1, screen_ram_pkg::OFS_WRITE_OPTIONS_REG, 32'h0000_00A8);
    do_mod(10'd4, 9'd4, 16'h5000);
    chk({28'h0, u_screen_ram_model.mem[{1'b0, 6'd0, 7'd1}][15:12]}, 32'h0000_000A);
    // single use per shift; the pattern rotates back round
    bus(1'b1, screen_ram_pkg::OFS_WRITE_OPTIONS_REG, 32'h0000_0002);
    bus(1'b1, screen_ram_pkg::OFS_PAT, 32'h0000_0001);
    for (int i = 0; i < 9; i++) begin
      do_mod(10'(300 + 5 * i), 9'd8, 16'hFFFF);
      chk({31'h0, w[0]}, {31'h0, (i % 8) == 0});
    end
    // multiplier E is two uses per pattern bit before the shift
    bus(1'b1, screen_ram_pkg::OFS_MULT, 32'h0000_000E);
    bus(1'b1, screen_ram_pkg::OFS_PAT, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      do_mod(10'(400 + 5 * i), 9'd12, 16'hFFFF);
      chk({31'h0, w[0]}, {31'h0, i < 2});
    end
    $display("test pattern done");
    // short frame: 5 rows, sync on rows 1 to 4
    bus(1'b1, screen_ram_pkg::OFS_VTOTAL, 32'h0000_0004);
    bus(1'b1, screen_ram_pkg::OFS_VDISP, 32'h0000_0001);
    bus(1'b1, screen_ram_pkg::OFS_VSYNC, 32'h0000_0001);
    run_len(1'b1, 1'b0, lo);
    run_len(1'b1, 1'b1, lo);
    run_len(1'b1, 1'b0, lo);
    // sync rows lie past the single displayed row: blanked and dark
    chk({31'h0, blank}, 32'h0000_0001);
    chk({31'h0, video}, 32'h0000_0000);
    run_len(1'b1, 1'b1, hi);
    chk(lo, 32'(4 * P));
    chk(hi, 32'(16 * P));
    $display("test frame done");
    conclude();
  end
endmodule
`default_nettype wire
